// ==== hdl/mgb_consts.vh ====
`ifndef MGB_CONSTS_VH
`define MGB_CONSTS_VH

// ==========================================================
// Bus geometry
`define MGB_ADDR_W       12
`define MGB_DATA_W       32
`define MGB_HALF_W       16
`define MGB_B0_W         32
`define MGB_B1_W         22

// ==========================================================
// AHB-Lite encodings
`define MGB_HTRANS_NONSEQ 2'h2
`define MGB_HTRANS_SEQ    2'h3
`define MGB_HSIZE_WORD    3'h2
`define MGB_HRESP_OKAY    1'h0

// ==========================================================
// Register byte offsets
`define MGB_OFF_MASKED_OUT_B0_HI 12'h004
`define MGB_OFF_B0_DIR           12'h204
`define MGB_OFF_B0_OUT_EN        12'h208
`define MGB_OFF_B0_IRQ_MASK      12'h20C
`define MGB_OFF_B0_IRQ_DIS       12'h214
`define MGB_OFF_B1_DIR           12'h244
`define MGB_OFF_B1_IRQ_MASK      12'h24C
`define MGB_OFF_B1_IRQ_EN        12'h250
`define MGB_OFF_B1_IRQ_DIS       12'h254
`define MGB_OFF_B1_IRQ_STAT      12'h258
`define MGB_OFF_B1_IRQ_TYPE      12'h25C
`define MGB_OFF_B1_IRQ_POL       12'h260
`define MGB_OFF_B1_IRQ_ANY       12'h264

// ==========================================================
// Field positions
`define MGB_MASK_MSB 31
`define MGB_MASK_LSB 16
`define MGB_VAL_MSB  15
`define MGB_VAL_LSB  0
`define MGB_B1_MSB   21

// ==========================================================
// Reset values
`define MGB_RST_ZERO32   32'h00000000
`define MGB_RST_ZERO22   22'h000000
`define MGB_RST_ZERO16   16'h0000
`define MGB_RST_MASK_B0  32'hFFFFFFFF
`define MGB_RST_MASK_B1  22'h3FFFFF

`endif

// ==== hdl/mgb_irq_detect.v ====
`timescale 1ns/10ps
`default_nettype none

module mgb_irq_detect #(
   parameter WIDTH = 22
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] pin_in,
   input  wire [WIDTH-1:0] edge_mode,
   input  wire [WIDTH-1:0] polarity,
   input  wire [WIDTH-1:0] both_edges,
   output reg  [WIDTH-1:0] event_hit
);

   reg [WIDTH-1:0] prev_r;
   reg             prev_ok_r;
   reg [WIDTH-1:0] rise;
   reg [WIDTH-1:0] fall;
   reg [WIDTH-1:0] edge_hit;
   reg [WIDTH-1:0] level_hit;

   // ==========================================================
   // Previous pin level, edges ignored until one sample is held
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r    <= {WIDTH{1'b0}};
         prev_ok_r <= 1'b0;
      end else begin
         prev_r    <= pin_in;
         prev_ok_r <= 1'b1;
      end
   end

   // ==========================================================
   // Per-pin event select
   always @* begin
      rise      = prev_ok_r ? (pin_in & ~prev_r) : {WIDTH{1'b0}};
      fall      = prev_ok_r ? (~pin_in & prev_r) : {WIDTH{1'b0}};
      edge_hit  = (both_edges & (rise | fall))
                | (~both_edges & ((polarity & rise) | (~polarity & fall)));
      level_hit = (polarity & pin_in) | (~polarity & ~pin_in);
      event_hit = (edge_mode & edge_hit) | (~edge_mode & level_hit);
   end

endmodule

`default_nettype wire

// ==== hdl/mgb_gpio_ctrl.v ====
// Functional notes
// - Masked output write updates pins 16-31 only where upper-half mask bit is zero.
// - Lower half of masked output write carries new levels for pins 16-31.
// - Reading the value half returns the held output levels after masking, never the live pin.
// - Bank 0 direction: 32 bits read/write, one means output, resets to zero.
// - Bank 0 output enable: 32 bits read/write, one enables driver only where the direction bit is also one, resets zero.
// - Bank 1 direction: 22 bits for pins 32-53, one means output, resets zero.
// - Bits 31 to 22 of every bank 1 register are ignored on write.
// - Bank 1 enable register is write-only; a one unmasks, zero leaves unchanged.
// - Bank 1 disable register is write-only; a one masks, zero leaves unchanged.
// - Bank 0 disable register is write-only; a one masks, zero leaves unchanged.
// - Bank 1 status bit sets on pin event; write one clears, zero does nothing.
// - Bank 1 type bit: zero level-sensitive, one edge-sensitive; resets to zero.
// - Bank 1 polarity bit: zero low or falling, one high or rising.
// - Bank 1 any-edge bit: zero single configured edge, one both edges.
`timescale 1ns/10ps
`default_nettype none
`include "mgb_consts.vh"

module mgb_gpio_ctrl #(
   parameter B0_W   = `MGB_B0_W,
   parameter B1_W   = `MGB_B1_W,
   parameter HALF_W = `MGB_HALF_W
) (
   input  wire                    hclk,
   input  wire                    hresetn,
   input  wire                    hsel,
   input  wire [`MGB_ADDR_W-1:0]  haddr,
   input  wire [1:0]              htrans,
   input  wire                    hwrite,
   input  wire [2:0]              hsize,
   input  wire [`MGB_DATA_W-1:0]  hwdata,
   input  wire                    hready,
   output wire                    hreadyout,
   output reg  [`MGB_DATA_W-1:0]  hrdata,
   output wire                    hresp,
   output reg  [B0_W-1:0]         bank0_pin_out,
   output reg  [B0_W-1:0]         bank0_pin_oe,
   input  wire [B1_W-1:0]         bank1_pin_in,
   output reg  [B1_W-1:0]         bank1_dir_out,
   output reg                     irq
);

   // ==========================================================
   // Address match on word index
   function reg_hit;
      input [`MGB_ADDR_W-1:0] addr;
      input [`MGB_ADDR_W-1:0] off;
      begin
         reg_hit = (addr[`MGB_ADDR_W-1:2] == off[`MGB_ADDR_W-1:2]);
      end
   endfunction

   // ==========================================================
   // Bus phase state
   reg                     wr_pend_r;
   reg [`MGB_ADDR_W-1:0]   wr_addr_r;
   wire                    addr_take;
   wire                    wr_take;
   wire                    rd_take;

   // ==========================================================
   // Register state
   reg [HALF_W-1:0]        out_hi_r;
   reg [HALF_W-1:0]        out_hi_nxt;
   reg [B0_W-1:0]          dir0_r;
   reg [B0_W-1:0]          dir0_nxt;
   reg [B0_W-1:0]          oe0_r;
   reg [B0_W-1:0]          oe0_nxt;
   reg [B0_W-1:0]          mask0_r;
   reg [B0_W-1:0]          mask0_nxt;
   reg [B1_W-1:0]          dir1_r;
   reg [B1_W-1:0]          dir1_nxt;
   reg [B1_W-1:0]          mask1_r;
   reg [B1_W-1:0]          mask1_nxt;
   reg [B1_W-1:0]          stat1_r;
   reg [B1_W-1:0]          stat1_nxt;
   reg [B1_W-1:0]          type1_r;
   reg [B1_W-1:0]          type1_nxt;
   reg [B1_W-1:0]          pol1_r;
   reg [B1_W-1:0]          pol1_nxt;
   reg [B1_W-1:0]          any1_r;
   reg [B1_W-1:0]          any1_nxt;
   reg [`MGB_DATA_W-1:0]   rd_mux;

   // ==========================================================
   // Data-phase write strobes
   wire                    we_out_hi;
   wire                    we_dir0;
   wire                    we_oe0;
   wire                    we_dis0;
   wire                    we_dir1;
   wire                    we_en1;
   wire                    we_dis1;
   wire                    we_stat1;
   wire                    we_type1;
   wire                    we_pol1;
   wire                    we_any1;
   wire [HALF_W-1:0]       wr_mask_hi;
   wire [HALF_W-1:0]       wr_val_hi;
   wire [B1_W-1:0]         wr_b1;
   wire [B1_W-1:0]         pin_event;

   // ==========================================================
   // Pin event detection, bank 1
   mgb_irq_detect #(
      .WIDTH      (B1_W)
   ) u_detect (
      .clk        (hclk),
      .rst_n      (hresetn),
      .pin_in     (bank1_pin_in),
      .edge_mode  (type1_r),
      .polarity   (pol1_r),
      .both_edges (any1_r),
      .event_hit  (pin_event)
   );

   // ==========================================================
   // AHB-Lite slave, zero wait states
   assign hreadyout = 1'b1;
   assign hresp     = `MGB_HRESP_OKAY;
   assign addr_take = hsel & hready & ((htrans == `MGB_HTRANS_NONSEQ) | (htrans == `MGB_HTRANS_SEQ));
   assign wr_take   = addr_take & hwrite & (hsize == `MGB_HSIZE_WORD);
   assign rd_take   = addr_take & ~hwrite;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= {`MGB_ADDR_W{1'b0}};
      end else begin
         if (hready) begin
            wr_pend_r <= wr_take;
         end
         if (wr_take) begin
            wr_addr_r <= haddr;
         end
      end
   end

   assign we_out_hi = wr_pend_r & reg_hit(wr_addr_r, `MGB_OFF_MASKED_OUT_B0_HI);
   assign we_dir0   = wr_pend_r & reg_hit(wr_addr_r, `MGB_OFF_B0_DIR);
   assign we_oe0    = wr_pend_r & reg_hit(wr_addr_r, `MGB_OFF_B0_OUT_EN);
   assign we_dis0   = wr_pend_r & reg_hit(wr_addr_r, `MGB_OFF_B0_IRQ_DIS);
   assign we_dir1   = wr_pend_r & reg_hit(wr_addr_r, `MGB_OFF_B1_DIR);
   assign we_en1    = wr_pend_r & reg_hit(wr_addr_r, `MGB_OFF_B1_IRQ_EN);
   assign we_dis1   = wr_pend_r & reg_hit(wr_addr_r, `MGB_OFF_B1_IRQ_DIS);
   assign we_stat1  = wr_pend_r & reg_hit(wr_addr_r, `MGB_OFF_B1_IRQ_STAT);
   assign we_type1  = wr_pend_r & reg_hit(wr_addr_r, `MGB_OFF_B1_IRQ_TYPE);
   assign we_pol1   = wr_pend_r & reg_hit(wr_addr_r, `MGB_OFF_B1_IRQ_POL);
   assign we_any1   = wr_pend_r & reg_hit(wr_addr_r, `MGB_OFF_B1_IRQ_ANY);

   assign wr_mask_hi = hwdata[`MGB_MASK_MSB:`MGB_MASK_LSB];
   assign wr_val_hi  = hwdata[`MGB_VAL_MSB:`MGB_VAL_LSB];
   assign wr_b1      = hwdata[`MGB_B1_MSB:0];

   // ==========================================================
   // Next-state of software registers
   always @* begin
      out_hi_nxt = out_hi_r;
      dir0_nxt   = dir0_r;
      oe0_nxt    = oe0_r;
      mask0_nxt  = mask0_r;
      dir1_nxt   = dir1_r;
      mask1_nxt  = mask1_r;
      type1_nxt  = type1_r;
      pol1_nxt   = pol1_r;
      any1_nxt   = any1_r;
      if (we_out_hi) begin
         out_hi_nxt = (out_hi_r & wr_mask_hi)
                    | (wr_val_hi & ~wr_mask_hi);
      end
      if (we_dir0) begin
         dir0_nxt = hwdata;
      end
      if (we_oe0) begin
         oe0_nxt = hwdata;
      end
      if (we_dis0) begin
         mask0_nxt = mask0_r | hwdata;
      end
      if (we_dir1) begin
         dir1_nxt = wr_b1;
      end
      if (we_en1) begin
         mask1_nxt = mask1_nxt & ~wr_b1;
      end
      if (we_dis1) begin
         mask1_nxt = mask1_nxt | wr_b1;
      end
      if (we_type1) begin
         type1_nxt = wr_b1;
      end
      if (we_pol1) begin
         pol1_nxt = wr_b1;
      end
      if (we_any1) begin
         any1_nxt = wr_b1;
      end
   end

   // ==========================================================
   // Sticky status, pin event wins over write-one clear
   always @* begin
      stat1_nxt = stat1_r;
      if (we_stat1) begin
         stat1_nxt = stat1_r & ~wr_b1;
      end
      stat1_nxt = stat1_nxt | pin_event;
   end

   // ==========================================================
   // Bank 0 register flops
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_hi_r <= `MGB_RST_ZERO16;
      end else begin
         out_hi_r <= out_hi_nxt;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir0_r <= `MGB_RST_ZERO32;
      end else begin
         dir0_r <= dir0_nxt;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oe0_r <= `MGB_RST_ZERO32;
      end else begin
         oe0_r <= oe0_nxt;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask0_r <= `MGB_RST_MASK_B0;
      end else begin
         mask0_r <= mask0_nxt;
      end
   end

   // ==========================================================
   // Bank 1 configuration flops
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir1_r <= `MGB_RST_ZERO22;
      end else begin
         dir1_r <= dir1_nxt;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         type1_r <= `MGB_RST_ZERO22;
      end else begin
         type1_r <= type1_nxt;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pol1_r <= `MGB_RST_ZERO22;
      end else begin
         pol1_r <= pol1_nxt;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         any1_r <= `MGB_RST_ZERO22;
      end else begin
         any1_r <= any1_nxt;
      end
   end

   // ==========================================================
   // Bank 1 mask and status flops
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask1_r <= `MGB_RST_MASK_B1;
      end else begin
         mask1_r <= mask1_nxt;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat1_r <= `MGB_RST_ZERO22;
      end else begin
         stat1_r <= stat1_nxt;
      end
   end

   // ==========================================================
   // Read mux, fed from next values so a write just before is seen
   always @* begin
      rd_mux = `MGB_RST_ZERO32;
      if (reg_hit(haddr, `MGB_OFF_MASKED_OUT_B0_HI)) begin
         rd_mux[`MGB_VAL_MSB:`MGB_VAL_LSB] = out_hi_nxt;
      end else if (reg_hit(haddr, `MGB_OFF_B0_DIR)) begin
         rd_mux = dir0_nxt;
      end else if (reg_hit(haddr, `MGB_OFF_B0_OUT_EN)) begin
         rd_mux = oe0_nxt;
      end else if (reg_hit(haddr, `MGB_OFF_B0_IRQ_MASK)) begin
         rd_mux = mask0_nxt;
      end else if (reg_hit(haddr, `MGB_OFF_B1_DIR)) begin
         rd_mux[`MGB_B1_MSB:0] = dir1_nxt;
      end else if (reg_hit(haddr, `MGB_OFF_B1_IRQ_MASK)) begin
         rd_mux[`MGB_B1_MSB:0] = mask1_nxt;
      end else if (reg_hit(haddr, `MGB_OFF_B1_IRQ_STAT)) begin
         rd_mux[`MGB_B1_MSB:0] = stat1_nxt;
      end else if (reg_hit(haddr, `MGB_OFF_B1_IRQ_TYPE)) begin
         rd_mux[`MGB_B1_MSB:0] = type1_nxt;
      end else if (reg_hit(haddr, `MGB_OFF_B1_IRQ_POL)) begin
         rd_mux[`MGB_B1_MSB:0] = pol1_nxt;
      end else if (reg_hit(haddr, `MGB_OFF_B1_IRQ_ANY)) begin
         rd_mux[`MGB_B1_MSB:0] = any1_nxt;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= `MGB_RST_ZERO32;
      end else if (rd_take) begin
         hrdata <= rd_mux;
      end
   end

   // ==========================================================
   // Pin drivers and interrupt output
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bank0_pin_out <= `MGB_RST_ZERO32;
         bank0_pin_oe  <= `MGB_RST_ZERO32;
         bank1_dir_out <= `MGB_RST_ZERO22;
         irq           <= 1'b0;
      end else begin
         bank0_pin_out <= {out_hi_nxt, `MGB_RST_ZERO16};
         bank0_pin_oe  <= dir0_nxt & oe0_nxt;
         bank1_dir_out <= dir1_nxt;
         irq           <= |(stat1_nxt & ~mask1_nxt);
      end
   end

endmodule

`default_nettype wire

// ==== sim/mgb_gpio_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "mgb_consts.vh"
module mgb_gpio_monitor (
   input wire logic                   hclk,
   input wire logic                   hresetn,
   input wire logic                   hsel,
   input wire logic [`MGB_ADDR_W-1:0] haddr,
   input wire logic [1:0]             htrans,
   input wire logic                   hwrite,
   input wire logic [2:0]             hsize,
   input wire logic [31:0]            hwdata,
   input wire logic                   hready,
   input wire logic                   hreadyout,
   input wire logic [31:0]            hrdata,
   input wire logic                   hresp,
   input wire logic [31:0]            bank0_pin_out,
   input wire logic [31:0]            bank0_pin_oe,
   input wire logic [21:0]            bank1_dir_out,
   input wire logic                   irq
);
   logic        wr_r;
   logic [11:0] a_r;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ==========================================================
   // Data phase tracking
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_r <= 1'b0;
         a_r  <= 12'h000;
      end else begin
         wr_r <= hsel & hready & htrans[1] & hwrite & (hsize == `MGB_HSIZE_WORD);
         a_r  <= {haddr[11:2], 2'h0};
      end
   end
   sequence s_wr(logic [11:0] off);
      wr_r && a_r == off;
   endsequence
   // ==========================================================
   // Checks
   chk_ready_okay:
      assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
   chk_dir_gates_oe:
      assert property (s_wr(`MGB_OFF_B0_DIR) |=> (bank0_pin_oe & ~$past(hwdata)) == 32'h0)
      else $error("driver on for input pin");
   chk_dir1_follow:
      assert property (s_wr(`MGB_OFF_B1_DIR) |=> bank1_dir_out == $past(hwdata[21:0]))
      else $error("bank1 direction not loaded");
   chk_dir1_hold:
      assert property (!(wr_r && a_r == `MGB_OFF_B1_DIR) |=> $stable(bank1_dir_out))
      else $error("bank1 direction changed alone");
   chk_mask_keep:
      assert property (s_wr(`MGB_OFF_MASKED_OUT_B0_HI) |=>
         ((bank0_pin_out[31:16] ^ $past(bank0_pin_out[31:16])) & $past(hwdata[31:16])) == 16'h0)
      else $error("masked pin changed");
   chk_value_load:
      assert property (s_wr(`MGB_OFF_MASKED_OUT_B0_HI) |=>
         ((bank0_pin_out[31:16] ^ $past(hwdata[15:0])) & ~$past(hwdata[31:16])) == 16'h0)
      else $error("unmasked pin not loaded");
   chk_out_hold:
      assert property (!(wr_r && a_r == `MGB_OFF_MASKED_OUT_B0_HI) |=> $stable(bank0_pin_out))
      else $error("pin output changed alone");
   chk_irq_sticky:
      assert property (irq && !(wr_r && (a_r == `MGB_OFF_B1_IRQ_STAT || a_r == `MGB_OFF_B1_IRQ_DIS)) |=> irq)
      else $error("irq dropped without clear");
   chk_rdata_hold:
      assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
      else $error("read data changed alone");
endmodule
bind mgb_gpio_ctrl mgb_gpio_monitor u_mgb_gpio_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bank0_pin_out(bank0_pin_out),
   .bank0_pin_oe(bank0_pin_oe), .bank1_dir_out(bank1_dir_out), .irq(irq));
`default_nettype wire

// ==== sim/mgb_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module mgb_pin_model (
   input  wire logic [31:0] bank0_pin_out,
   input  wire logic [31:0] bank0_pin_oe,
   output var  logic [21:0] bank1_pin_in
);
   // Buttons idle high through pull-ups
   logic [21:0] level_r = 22'h3FFFFF;
   // LED lit only where the pin is driven high
   wire  [31:0] led_lit = bank0_pin_oe & bank0_pin_out;
   assign bank1_pin_in = level_r;
   task automatic set_level(input int idx, input logic v);
      level_r[idx] <= v;
   endtask
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "mgb_consts.vh"
module testbench;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = `MGB_HSIZE_WORD;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   wire         hreadyout;
   wire         hresp;
   wire         irq;
   wire  [31:0] hrdata;
   wire  [31:0] bank0_pin_out;
   wire  [31:0] bank0_pin_oe;
   wire  [21:0] bank1_pin_in;
   wire  [21:0] bank1_dir_out;
   int          errors = 0;
   int          checks_done = 0;
   mgb_gpio_ctrl u_mgb_gpio_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bank0_pin_out(bank0_pin_out),
      .bank0_pin_oe(bank0_pin_oe), .bank1_pin_in(bank1_pin_in), .bank1_dir_out(bank1_dir_out), .irq(irq));
   mgb_pin_model u_mgb_pin_model (.bank0_pin_out(bank0_pin_out), .bank0_pin_oe(bank0_pin_oe),
      .bank1_pin_in(bank1_pin_in));
   initial begin
      forever #2 hclk = ~hclk;
   end
   // ==========================================================
   // Bus and compare tasks
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= `MGB_HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      cmp(nm, exp, rd);
   endtask
   task automatic pin(input int i, input logic v);
      @(posedge hclk);
      u_mgb_pin_model.set_level(i, v);
      repeat (3) @(posedge hclk);
   endtask
   task automatic results;
      $display("Checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #80000;
      errors++;
      results;
   end
   // ==========================================================
   // Tests
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      rchk("dir0", `MGB_OFF_B0_DIR, 32'h0);
      rchk("oe0", `MGB_OFF_B0_OUT_EN, 32'h0);
      rchk("dir1", `MGB_OFF_B1_DIR, 32'h0);
      rchk("type1", `MGB_OFF_B1_IRQ_TYPE, 32'h0);
      rchk("pol1", `MGB_OFF_B1_IRQ_POL, 32'h0);
      rchk("any1", `MGB_OFF_B1_IRQ_ANY, 32'h0);
      rchk("stat1", `MGB_OFF_B1_IRQ_STAT, 32'h0);
      rchk("en1", `MGB_OFF_B1_IRQ_EN, 32'h0);
      rchk("dis0", `MGB_OFF_B0_IRQ_DIS, 32'h0);
      rchk("mask1", `MGB_OFF_B1_IRQ_MASK, 32'h003FFFFF);
      bus(1'b1, 12'h100, 32'hFFFFFFFF);
      rchk("unmapped", 12'h100, 32'h0);
      $display("Test reset values done");
      bus(1'b1, `MGB_OFF_B0_DIR, 32'h00070000);
      bus(1'b1, `MGB_OFF_B0_OUT_EN, 32'h00050003);
      rchk("dir0", `MGB_OFF_B0_DIR, 32'h00070000);
      rchk("oe0", `MGB_OFF_B0_OUT_EN, 32'h00050003);
      cmp("pin_oe", 32'h00050000, bank0_pin_oe);
      hsize <= 3'h0;
      bus(1'b1, `MGB_OFF_B0_DIR, 32'hFFFFFFFF);
      hsize <= `MGB_HSIZE_WORD;
      rchk("dir0_size", `MGB_OFF_B0_DIR, 32'h00070000);
      bus(1'b1, `MGB_OFF_B1_DIR, 32'hFFFFFFFF);
      rchk("dir1", `MGB_OFF_B1_DIR, 32'h003FFFFF);
      cmp("dir1_out", 32'h003FFFFF, {10'h0, bank1_dir_out});
      $display("Test direction done");
      bus(1'b1, `MGB_OFF_MASKED_OUT_B0_HI, 32'h0000A5C3);
      rchk("mout", `MGB_OFF_MASKED_OUT_B0_HI, 32'h0000A5C3);
      bus(1'b1, `MGB_OFF_MASKED_OUT_B0_HI, 32'hFF00FFFF);
      rchk("mout", `MGB_OFF_MASKED_OUT_B0_HI, 32'h0000A5FF);
      cmp("pin_out", 32'hA5FF0000, bank0_pin_out);
      cmp("led", 32'h00050000, u_mgb_pin_model.led_lit);
      $display("Test masked output done");
      bus(1'b1, `MGB_OFF_B1_IRQ_TYPE, 32'hFFC00001);
      rchk("type1", `MGB_OFF_B1_IRQ_TYPE, 32'h00000001);
      bus(1'b1, `MGB_OFF_B1_IRQ_POL, 32'h00000001);
      bus(1'b1, `MGB_OFF_B1_IRQ_EN, 32'hFFC00001);
      rchk("mask1", `MGB_OFF_B1_IRQ_MASK, 32'h003FFFFE);
      pin(0, 1'b0);
      rchk("fall", `MGB_OFF_B1_IRQ_STAT, 32'h0);
      pin(0, 1'b1);
      cmp("irq", 32'h1, {31'h0, irq});
      bus(1'b1, `MGB_OFF_B1_IRQ_STAT, 32'h0);
      rchk("stat1", `MGB_OFF_B1_IRQ_STAT, 32'h1);
      bus(1'b1, `MGB_OFF_B1_IRQ_STAT, 32'h1);
      rchk("stat1", `MGB_OFF_B1_IRQ_STAT, 32'h0);
      cmp("irq", 32'h0, {31'h0, irq});
      bus(1'b1, `MGB_OFF_B1_IRQ_ANY, 32'h1);
      pin(0, 1'b0);
      rchk("any", `MGB_OFF_B1_IRQ_STAT, 32'h1);
      bus(1'b1, `MGB_OFF_B1_IRQ_STAT, 32'h1);
      bus(1'b1, `MGB_OFF_B1_IRQ_DIS, 32'h1);
      rchk("mask1", `MGB_OFF_B1_IRQ_MASK, 32'h003FFFFF);
      pin(0, 1'b1);
      rchk("stat1", `MGB_OFF_B1_IRQ_STAT, 32'h1);
      cmp("irq", 32'h0, {31'h0, irq});
      bus(1'b1, `MGB_OFF_B1_IRQ_STAT, 32'h1);
      bus(1'b1, `MGB_OFF_B1_IRQ_EN, 32'h2);
      pin(1, 1'b0);
      cmp("irq", 32'h1, {31'h0, irq});
      pin(1, 1'b1);
      bus(1'b1, `MGB_OFF_B1_IRQ_STAT, 32'h2);
      rchk("lvl", `MGB_OFF_B1_IRQ_STAT, 32'h0);
      cmp("irq", 32'h0, {31'h0, irq});
      bus(1'b1, `MGB_OFF_B0_IRQ_DIS, 32'hFFFFFFFF);
      rchk("mask0", `MGB_OFF_B0_IRQ_MASK, 32'hFFFFFFFF);
      $display("Test interrupts done");
      results;
   end
endmodule
`default_nettype wire
